// [pkg/sai_defs.svh]
`ifndef SAI_DEFS_SVH
`define SAI_DEFS_SVH

// register map
`define SAI_CFG_ADDR 8'h01
`define SAI_CFG_RST 8'h80

// configuration field positions
`define SAI_FMT_LSB 0
`define SAI_FMT_MSB 3
`define SAI_ORDER_BIT 4
`define SAI_DLY_BIT 5
`define SAI_CH1_BIT 6
`define SAI_CH2_BIT 7

// format codes with a special meaning
`define SAI_CODE_I2S15_LSB16 4'hC
`define SAI_CODE_RJ16 4'hE

// word lengths
`define SAI_LEN_24 5'd24
`define SAI_LEN_20 5'd20
`define SAI_LEN_18 5'd18
`define SAI_LEN_16 5'd16
`define SAI_LEN_15 5'd15

// half frame length at 32x bit clock
`define SAI_HALF_32X 6'd16

// longest half frame kept in the shifter
`define SAI_SHIFT_W 32
`define SAI_CNT_MAX 6'h3F

`endif

// [pkg/sai_pkg.sv]
package sai_pkg;

    // justification, from the two low bits of the format code
    typedef enum logic [1:0] {
        SAI_JUST_I2S = 2'b00,
        SAI_JUST_LEFT = 2'b01,
        SAI_JUST_RIGHT = 2'b10,
        SAI_JUST_SPARE = 2'b11
    } sai_just_t;

    // word length select, from the two high bits of the format code
    typedef enum logic [1:0] {
        SAI_LEN_SEL_24 = 2'b00,
        SAI_LEN_SEL_20 = 2'b01,
        SAI_LEN_SEL_18 = 2'b10,
        SAI_LEN_SEL_16 = 2'b11
    } sai_len_sel_t;

endpackage

// [hw/sai_word_extract.sv]
`include "sai_defs.svh"

module sai_word_extract import sai_pkg::*; #(
    parameter int OUT_W = 24
) (
    // one completed half frame, oldest bit highest
    input wire logic [`SAI_SHIFT_W-1:0] half_bits,
    input wire logic [5:0] half_len,
    // configuration
    input wire logic [3:0] input_format_code,
    input wire logic input_bit_order,
    // word, msb aligned to the top of OUT_W
    output logic [OUT_W-1:0] word
);

    sai_just_t just;
    logic [4:0] len;
    logic [31:0] field;
    logic [31:0] rev;
    logic [31:0] chosen;
    logic lsb_first;

    assign just = sai_just_t'(input_format_code[1:0]);

    always_comb begin
        case (sai_len_sel_t'(input_format_code[3:2]))
            SAI_LEN_SEL_24: len = `SAI_LEN_24;
            SAI_LEN_SEL_20: len = `SAI_LEN_20;
            SAI_LEN_SEL_18: len = `SAI_LEN_18;
            SAI_LEN_SEL_16: len = `SAI_LEN_16;
            default: len = `SAI_LEN_24;
        endcase
        // a 16 bit half frame with code 1100 carries a 15 bit word
        if (input_format_code == `SAI_CODE_I2S15_LSB16 && half_len <= `SAI_HALF_32X) begin
            len = `SAI_LEN_15;
        end
    end

    // bit order only matters for the 16 bit lsb-first layouts
    assign lsb_first = input_bit_order &&
        ((input_format_code == `SAI_CODE_I2S15_LSB16 && half_len > `SAI_HALF_32X) ||
        input_format_code == `SAI_CODE_RJ16);

    always_comb begin
        if (just == SAI_JUST_RIGHT) begin
            field = half_bits;
        end else if (half_len >= {1'b0, len}) begin
            field = half_bits >> (half_len - {1'b0, len});
        end else begin
            field = half_bits << ({1'b0, len} - half_len);
        end
        field = field & ((32'h1 << len) - 32'h1);
    end

    // reverse only the len bits of the field
    genvar i;
    generate
        for (i = 0; i < 32; i++) begin : g_rev
            assign rev[i] = (i < len) ? field[5'(len - 5'd1 - 5'(i))] : 1'b0;
        end
    endgenerate

    assign chosen = lsb_first ? rev : field;
    assign word = OUT_W'(chosen << (6'd32 - {1'b0, len}) >> (32 - OUT_W));

endmodule // sai_word_extract

// [hw/sai_rx.sv]
// How it works
// - the block is always the slave; the outside source makes both frame clock and bit clock.
// - two channels arrive on three lines: frame clock, bit clock and serial data.
// - bits 3..0 of the configuration register pick the word format and reset to 0000.
// - bit 4 picks msb-first at 0 and lsb-first at 1 for codes 1110 and 16 bit i2s 1100 only, reset 0.
// - bit clocks of 32, 48 and 64 per frame are taken, at 32 to 192 kHz frame rates.
// - at 32 bits per frame, code 1100 takes 15 bit words and 1110 takes 16 bit words.
// - at 64 bits per frame, codes 0000, 0100 and 1000 take i2s words of 24, 20 and 18 bits.
// - at 48 bits per frame, code 0100 takes 20 bit i2s words and 1000 takes 18 bit ones.
// - 16 bit i2s is msb-first with order 0, lsb-first with order 1 and code 1100.
// - codes ending 01 are left justified, ending 10 right justified, top bits giving 24/20/18/16.
// - bit 5 set delays the bit clock by one core clock before use, reset 0.
// - bit 6 sends left to processing channel 1 at 0 and right at 1, reset 0.
// - bit 7 sends left to processing channel 2 at 0 and right at 1, reset 1.
// - each processing channel picks its source alone, so both may take the same input.
`include "sai_defs.svh"

module sai_rx import sai_pkg::*; #(
    parameter int OUT_W = 24
) (
    // core clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // serial audio input pins
    input wire logic frame_clock_in,
    input wire logic bit_clock_in,
    input wire logic serial_data_in,
    // configuration register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // processing channels
    output logic [OUT_W-1:0] proc_ch1_data,
    output logic [OUT_W-1:0] proc_ch2_data,
    output logic proc_valid,
    // measured bits in the last half frame
    output logic [5:0] half_frame_bits
);

    logic [7:0] serial_input_config;
    logic [3:0] input_format_code;
    logic input_bit_order;
    logic bit_clock_delay_en;
    logic proc_ch1_source_sel;
    logic proc_ch2_source_sel;

    logic [1:0] lr_sync;
    logic [1:0] data_sync;
    logic [2:0] bclk_sync;
    logic bclk_use;
    logic bclk_prev;
    logic bclk_rise;

    logic ws_prev;
    logic ws_hold;
    logic ws_now;
    logic is_i2s;
    logic left_level;
    logic boundary;
    logic synced;

    logic [`SAI_SHIFT_W-1:0] shifter;
    logic [5:0] bit_cnt;
    logic [OUT_W-1:0] word;
    logic [OUT_W-1:0] left_word;
    logic [OUT_W-1:0] right_word;
    logic have_left;

    // configuration register
    assign input_format_code = serial_input_config[`SAI_FMT_MSB:`SAI_FMT_LSB];
    assign input_bit_order = serial_input_config[`SAI_ORDER_BIT];
    assign bit_clock_delay_en = serial_input_config[`SAI_DLY_BIT];
    assign proc_ch1_source_sel = serial_input_config[`SAI_CH1_BIT];
    assign proc_ch2_source_sel = serial_input_config[`SAI_CH2_BIT];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            serial_input_config <= `SAI_CFG_RST;
        end else if (reg_wr && reg_addr == `SAI_CFG_ADDR) begin
            serial_input_config <= reg_wdata;
        end
    end

    // unmapped addresses read as zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_addr == `SAI_CFG_ADDR) begin
            reg_rdata <= serial_input_config;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // pins come from the outside master, so sync them first
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lr_sync <= 2'b00;
            data_sync <= 2'b00;
            bclk_sync <= 3'b000;
        end else begin
            lr_sync <= {lr_sync[0], frame_clock_in};
            data_sync <= {data_sync[0], serial_data_in};
            bclk_sync <= {bclk_sync[1:0], bit_clock_in};
        end
    end

    // the extra stage moves the sampling point one core clock later,
    // which helps masters whose data changes close to the rising edge
    assign bclk_use = bit_clock_delay_en ? bclk_sync[2] : bclk_sync[1];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bclk_prev <= 1'b0;
        end else begin
            bclk_prev <= bclk_use;
        end
    end

    assign bclk_rise = bclk_use && !bclk_prev;

    // i2s words start one bit after the frame clock edge, so the frame clock
    // seen one bit late marks the word boundary; justified formats use it live
    assign is_i2s = sai_just_t'(input_format_code[1:0]) == SAI_JUST_I2S;
    assign ws_now = is_i2s ? ws_prev : lr_sync[1];
    assign left_level = is_i2s ? 1'b0 : 1'b1;
    assign boundary = bclk_rise && (ws_now != ws_hold);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ws_prev <= 1'b0;
            ws_hold <= 1'b0;
        end else if (bclk_rise) begin
            ws_prev <= lr_sync[1];
            ws_hold <= ws_now;
        end
    end

    // collect one half frame of bits; any length up to 32 is taken
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shifter <= '0;
            bit_cnt <= 6'd0;
        end else if (boundary) begin
            shifter <= {{(`SAI_SHIFT_W-1){1'b0}}, data_sync[1]};
            bit_cnt <= 6'd1;
        end else if (bclk_rise) begin
            shifter <= {shifter[`SAI_SHIFT_W-2:0], data_sync[1]};
            if (bit_cnt != `SAI_CNT_MAX) begin
                bit_cnt <= bit_cnt + 6'd1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            half_frame_bits <= 6'd0;
        end else if (boundary && synced) begin
            half_frame_bits <= bit_cnt;
        end
    end

    sai_word_extract #(
        .OUT_W(OUT_W)
    ) u_extract (
        .half_bits(shifter),
        .half_len(bit_cnt),
        .input_format_code(input_format_code),
        .input_bit_order(input_bit_order),
        .word(word)
    );

    // the half frame cut short by reset is thrown away
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            synced <= 1'b0;
        end else if (boundary) begin
            synced <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            left_word <= '0;
            right_word <= '0;
            have_left <= 1'b0;
        end else if (boundary && synced) begin
            if (ws_hold == left_level) begin
                left_word <= word;
                have_left <= 1'b1;
            end else begin
                right_word <= word;
                have_left <= 1'b0;
            end
        end
    end

    // a pair is handed on when its right half closes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            proc_ch1_data <= '0;
            proc_ch2_data <= '0;
            proc_valid <= 1'b0;
        end else if (boundary && synced && ws_hold != left_level && have_left) begin
            proc_ch1_data <= proc_ch1_source_sel ? word : left_word;
            proc_ch2_data <= proc_ch2_source_sel ? word : left_word;
            proc_valid <= 1'b1;
        end else begin
            proc_valid <= 1'b0;
        end
    end

endmodule // sai_rx

// [dv/sai_rx_checker.sv]
module sai_rx_checker #(
    parameter int OUT_W = 24
) (
    // clock, reset
    input wire logic clk,
    input wire logic rst_n,
    // pins, registers
    input wire logic bit_clock_in,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // channels
    input wire logic [OUT_W-1:0] proc_ch1_data,
    input wire logic [OUT_W-1:0] proc_ch2_data,
    input wire logic proc_valid
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    logic [7:0] cfg;
    logic [4:0] idle;
    wire logic wr_cfg = reg_wr && reg_addr == 8'h01;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg <= 8'h80;
        end else if (wr_cfg) begin
            cfg <= reg_wdata;
        end
    end
    // cycles since bit clock moved
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            idle <= 5'h00;
        end else if ($changed(bit_clock_in)) begin
            idle <= 5'h00;
        end else if (idle != 5'h1F) begin
            idle <= idle + 5'h01;
        end
    end
    a_rd_back: assert property (wr_cfg ##1 reg_addr == 8'h01 |=> reg_rdata == $past(reg_wdata, 2))
        else $error("readback wrong");
    a_rd_unmapped: assert property (reg_addr != 8'h01 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_rd_held: assert property (reg_addr == 8'h01 && !wr_cfg ##1 reg_addr == 8'h01 |=> $stable(reg_rdata))
        else $error("config changed without write");
    a_valid_gap: assert property (proc_valid |=> !proc_valid [*8])
        else $error("valid not single");
    a_data_valid: assert property (!proc_valid |-> $stable(proc_ch1_data) && $stable(proc_ch2_data))
        else $error("data moved without valid");
    a_same_src: assert property (proc_valid && cfg[6] == cfg[7] |-> proc_ch1_data == proc_ch2_data)
        else $error("same source differs");
    a_idle_quiet: assert property (idle > 5'd16 |-> !proc_valid)
        else $error("valid with bit clock stopped");
    a_bclk_cause: assert property (proc_valid |-> $past(bit_clock_in, 2) || $past(bit_clock_in, 3))
        else $error("valid not after bit clock rise");
    c_valid: cover property (proc_valid);
    c_write: cover property (wr_cfg);
    c_swap: cover property (proc_valid && cfg[6] != cfg[7]);
endmodule // sai_rx_checker

bind sai_rx sai_rx_checker #(.OUT_W(OUT_W)) sai_rx_checker_i (.clk(clk), .rst_n(rst_n),
    .bit_clock_in(bit_clock_in), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .proc_ch1_data(proc_ch1_data), .proc_ch2_data(proc_ch2_data),
    .proc_valid(proc_valid));

// [dv/sai_src.sv]
module sai_src (
    // lines to the receiver
    output logic frame_clock_in,
    output logic bit_clock_in,
    output logic serial_data_in
);
    timeunit 1ns;
    timeprecision 1ns;
    int half = 32;
    int len = 24;
    int just = 0;
    bit lsb = 0;
    initial begin
        frame_clock_in = 1'b0;
        bit_clock_in = 1'b0;
        serial_data_in = 1'b0;
    end
    // clock stops after the stream; pad bits toggle so stale data never matches
    task automatic send(input logic [23:0] l, input logic [23:0] r, input int n);
        int j;
        int h;
        for (int s = 0; s < n * 2 * half + 2; s++) begin
            h = (s / half) % 2;
            j = s % half - (just == 0 ? 1 : just == 2 ? half - len : 0);
            frame_clock_in = (h == 1) ^ (just != 0);
            if (j >= 0 && j < len && s < n * 2 * half) begin
                serial_data_in = lsb ? (h ? r[24-len+j] : l[24-len+j]) : (h ? r[23-j] : l[23-j]);
            end else begin
                serial_data_in = ~serial_data_in;
            end
            #400 bit_clock_in = 1'b1;
            #400 bit_clock_in = 1'b0;
        end
    endtask
endmodule // sai_src

// [dv/tb_sai_rx.sv]
module tb_sai_rx;
    timeunit 1ns;
    timeprecision 1ns;
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin error_cnt++; $display("[ERR] %s exp %h got %h", n, e, a); end end
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic reg_wr = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic [23:0] ch1, ch2, c1, c2;
    logic [5:0] hfb;
    logic valid;
    wire fck, bck, sd;
    int error_cnt = 0;
    int checks = 0;
    int nv = 0;
    // the last three reach left justified 16, right justified 24 and an ignored order bit
    logic [7:0] tc [17] = '{8'h80, 8'h84, 8'h88, 8'h84, 8'h8C, 8'h8E, 8'h81, 8'h8A, 8'h9C, 8'h9E, 8'hA0,
        8'h00, 8'hC0, 8'h40, 8'h8D, 8'h82, 8'h96};
    int th [17] = '{32, 32, 32, 24, 16, 16, 32, 24, 32, 32, 32, 32, 32, 32, 24, 32, 32};
    int tl [17] = '{24, 20, 18, 20, 15, 16, 24, 18, 16, 16, 24, 24, 24, 24, 16, 24, 20};
    always #50 clk = ~clk;
    sai_src sai_src_i (.frame_clock_in(fck), .bit_clock_in(bck), .serial_data_in(sd));
    sai_rx sai_rx_i (.clk(clk), .rst_n(rst_n), .frame_clock_in(fck), .bit_clock_in(bck), .serial_data_in(sd),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .proc_ch1_data(ch1), .proc_ch2_data(ch2), .proc_valid(valid), .half_frame_bits(hfb));
    always @(posedge clk) begin
        if (valid === 1'b1) begin
            c1 <= ch1;
            c2 <= ch2;
            nv <= nv + 1;
        end
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wr <= 1'b1;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        repeat (2) @(posedge clk);
        #1 d = reg_rdata;
    endtask
    task automatic end_of_test;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // rough stream length is 2.5 ms
    initial begin
        #6000000;
        error_cnt++;
        end_of_test;
    end
    initial begin
        logic [7:0] d;
        logic [23:0] l, r, m;
        int nv0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rd(8'h01, d);
        `CHK("cfg rst", 8'h80, d)
        wr(8'h02, 8'hFF);
        rd(8'h02, d);
        `CHK("unmapped", 8'h00, d)
        rd(8'h01, d);
        `CHK("cfg kept", 8'h80, d)
        for (int t = 0; t < 17; t++) begin
            wr(8'h01, tc[t]);
            rd(8'h01, d);
            `CHK("cfg", tc[t], d)
            l = 24'hC35A69 ^ {3{t[7:0]}};
            r = ~l;
            m = 24'hFFFFFF << (24 - tl[t]);
            sai_src_i.half = th[t];
            sai_src_i.len = tl[t];
            sai_src_i.just = tc[t][1:0] == 2'b10 ? 2 : tc[t][1:0] == 2'b00 ? 0 : 1;
            // order bit only counts for 1110 and for 1100 with a long half frame
            sai_src_i.lsb = tc[t][4] && (tc[t][3:0] == 4'hE || (tc[t][3:0] == 4'hC && th[t] > 16));
            nv0 = nv;
            #37;
            sai_src_i.send(l, r, 3);
            repeat (20) @(posedge clk);
            `CHK("pairs", 1'b1, nv > nv0)
            `CHK("bits", 6'(th[t]), hfb)
            `CHK("ch1", (tc[t][6] ? r : l) & m, c1)
            `CHK("ch2", (tc[t][7] ? r : l) & m, c2)
            $display("test %0d done", t);
        end
        end_of_test;
    end
endmodule // tb_sai_rx
